// File: include/pls_defs.vh
`ifndef PLS_DEFS_VH
`define PLS_DEFS_VH

// Error code words, stored as 16-bit BCD-looking hex patterns
`define PLS_CODE_NONE      16'h0000
`define PLS_CODE_CH1_CHAR  16'h6312
`define PLS_CODE_CH1_SUM   16'h6313
`define PLS_CODE_CH1_FMT   16'h6314
`define PLS_CODE_CH2_CHAR  16'h3812
`define PLS_CODE_CH2_SUM   16'h3813
`define PLS_CODE_CH2_FMT   16'h3814

// Error kind field of the event input
`define PLS_KIND_CHAR      2'h1
`define PLS_KIND_SUM       2'h2
`define PLS_KIND_FMT       2'h3

// Indicator flash timing: on and off half period in ns
`define PLS_FLASH_HALF_NS  40
`define PLS_CLK_NS         8
`define PLS_FLASH_HALF_CYC ((`PLS_FLASH_HALF_NS) / (`PLS_CLK_NS))
`define PLS_FLASH_W        4

// Controller variants
`define PLS_VAR_NEW        1'h1
`define PLS_VAR_OLD        1'h0

`endif

// File: hdl/pls_flasher.v
`include "pls_defs.vh"

module pls_flasher (
    // Clock and reset
    input  wire clk,
    input  wire rst_n,
    // Activity in, indicator out
    input  wire active,
    output reg  led
);

    reg [`PLS_FLASH_W-1:0] count;

    // Last count of a half period, cut to the counter width on purpose
    localparam [31:0] FLASH_LAST = `PLS_FLASH_HALF_CYC - 1;

    always @(posedge clk) begin
        if (!rst_n) begin
            count <= {`PLS_FLASH_W{1'b0}};
            led   <= 1'b0;
        end else if (!active) begin
            // Idle direction keeps the indicator dark
            count <= {`PLS_FLASH_W{1'b0}};
            led   <= 1'b0;
        end else if (count == FLASH_LAST[`PLS_FLASH_W-1:0]) begin
            count <= {`PLS_FLASH_W{1'b0}};
            led   <= ~led;
        end else begin
            count <= count + {{(`PLS_FLASH_W-1){1'b0}}, 1'b1};
        end
    end

endmodule

// File: hdl/pls_status.v
// Function
// - Flash indicators while receiving or sending
// - Link-active flag drops on any error
// - Flag bad master/slave station declarations
// - Raise serial error flag of used channel
// - Store error code with the flag
// - First channel codes 6312, 6313, 6314
// - Second channel codes 3812, 3813, 3814
// - Error flags and codes stay sticky
// - Clear on power cycle or stop-to-run
// - No traffic on doubly assigned port
// - Volume instructions disable a channel
// - Channel-select bit picks the link port
`include "pls_defs.vh"

module pls_status (
    // Clock and reset
    input  wire        clk,
    input  wire        rst_n,
    // Configuration
    input  wire        master_declare,
    input  wire        slave_declare,
    input  wire        channel_select_bit,
    input  wire        network_enable,
    input  wire        port_multi_assigned,
    input  wire        volume_read_instruction,
    input  wire        volume_scale_instruction,
    input  wire        variant_new,
    input  wire        variant_high_end,
    // Run mode and power
    input  wire        run_mode,
    input  wire        power_on_pulse,
    // Link activity and errors
    input  wire        link_ok,
    input  wire        rx_busy,
    input  wire        tx_busy,
    input  wire        comm_error,
    input  wire [1:0]  error_kind,
    // Status out
    output wire        receive_activity_indicator,
    output wire        transmit_activity_indicator,
    output reg         link_active_flag,
    output reg         station_setting_error_flag,
    output reg         serial_error_flag_first_channel,
    output reg         serial_error_flag_second_channel,
    output reg  [15:0] error_code_word_first_channel,
    output reg  [15:0] error_code_word_second_channel,
    output reg         channel_enable_first,
    output reg         channel_enable_second
);

    ////////////////////////////////////////////////////////////////////////
    // Channel permission

    reg  run_q;
    wire volume_used;
    wire ch1_blocked;
    wire ch2_blocked;
    wire port_ok;
    wire clear_ev;
    wire setting_err;
    wire err_ch1;
    wire err_ch2;
    reg  [15:0] next_code1;
    reg  [15:0] next_code2;

    // Next-state values of the registered outputs
    reg         next_flag1;
    reg         next_flag2;
    reg  [15:0] next_word1;
    reg  [15:0] next_word2;
    wire        sel_flag;
    wire        next_link_active;

    assign volume_used = volume_read_instruction | volume_scale_instruction;
    assign ch2_blocked = volume_used & ~variant_high_end;
    assign ch1_blocked = volume_used & variant_high_end;
    // A refused port also ignores its errors, so it never leaves
    // a record behind that no traffic could have caused.
    // single port assignment; network exclusion checked here too
    assign port_ok = ~port_multi_assigned & ~network_enable &
                     (channel_select_bit ? ~ch2_blocked : ~ch1_blocked);

    assign setting_err = ~(master_declare ^ slave_declare);

    // run_q is low after reset, so on old parts an idle-high run pin gives one
    // clear there; harmless, since every record is empty at that point.
    // clear source depends on variant; power cycle on new parts, stop-to-run edge on old ones
    assign clear_ev = (variant_new == `PLS_VAR_NEW) ? power_on_pulse
                                                    : (run_mode & ~run_q);

    // route error to selected channel; channel select
    assign err_ch1 = comm_error & ~channel_select_bit & port_ok;
    assign err_ch2 = comm_error & channel_select_bit & port_ok;

    ////////////////////////////////////////////////////////////////////////
    // Error code lookup

    // Kind 0 still raises the flag but stores the no-error code
    always @* begin
        next_code1 = `PLS_CODE_NONE;
        next_code2 = `PLS_CODE_NONE;
        case (error_kind)
            `PLS_KIND_CHAR: next_code1 = `PLS_CODE_CH1_CHAR;
            `PLS_KIND_SUM:  next_code1 = `PLS_CODE_CH1_SUM;
            `PLS_KIND_FMT:  next_code1 = `PLS_CODE_CH1_FMT;
            default:        next_code1 = `PLS_CODE_NONE;
        endcase
        case (error_kind)
            `PLS_KIND_CHAR: next_code2 = `PLS_CODE_CH2_CHAR;
            `PLS_KIND_SUM:  next_code2 = `PLS_CODE_CH2_SUM;
            `PLS_KIND_FMT:  next_code2 = `PLS_CODE_CH2_FMT;
            default:        next_code2 = `PLS_CODE_NONE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state of the channel error records

    // sticky first channel record; error beats clear
    always @* begin
        next_flag1 = serial_error_flag_first_channel;
        next_word1 = error_code_word_first_channel;
        if (err_ch1) begin
            next_flag1 = 1'b1;
            next_word1 = next_code1;
        end else if (clear_ev) begin
            next_flag1 = 1'b0;
            next_word1 = `PLS_CODE_NONE;
        end
    end

    always @* begin
        next_flag2 = serial_error_flag_second_channel;
        next_word2 = error_code_word_second_channel;
        if (err_ch2) begin
            next_flag2 = 1'b1;
            next_word2 = next_code2;
        end else if (clear_ev) begin
            next_flag2 = 1'b0;
            next_word2 = `PLS_CODE_NONE;
        end
    end

    // The chosen channel's flag is read from its register, so the
    // link stays down through the clear cycle itself.
    assign sel_flag = channel_select_bit ?
                      serial_error_flag_second_channel :
                      serial_error_flag_first_channel;
    assign next_link_active = link_ok & port_ok & ~setting_err &
                              ~comm_error & ~sel_flag;

    ////////////////////////////////////////////////////////////////////////
    // Status registers

    // Configuration status and clear-edge history
    always @(posedge clk) begin
        if (!rst_n) begin
            run_q                      <= 1'b0;
            station_setting_error_flag <= 1'b0;
            link_active_flag           <= 1'b0;
            channel_enable_first       <= 1'b0;
            channel_enable_second      <= 1'b0;
        end else begin
            run_q                      <= run_mode;
            station_setting_error_flag <= setting_err;
            link_active_flag           <= next_link_active;
            channel_enable_first       <= port_ok & ~channel_select_bit;
            channel_enable_second      <= port_ok & channel_select_bit;
        end
    end

    // Channel error records
    always @(posedge clk) begin
        if (!rst_n) begin
            serial_error_flag_first_channel  <= 1'b0;
            serial_error_flag_second_channel <= 1'b0;
            error_code_word_first_channel    <= `PLS_CODE_NONE;
            error_code_word_second_channel   <= `PLS_CODE_NONE;
        end else begin
            serial_error_flag_first_channel  <= next_flag1;
            serial_error_flag_second_channel <= next_flag2;
            error_code_word_first_channel    <= next_word1;
            error_code_word_second_channel   <= next_word2;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Activity indicators

    pls_flasher u_rx_led (
        .clk    (clk),
        .rst_n  (rst_n),
        .active (rx_busy & port_ok),
        .led    (receive_activity_indicator)
    );

    pls_flasher u_tx_led (
        .clk    (clk),
        .rst_n  (rst_n),
        .active (tx_busy & port_ok),
        .led    (transmit_activity_indicator)
    );

endmodule

// File: testbench/pls_status_chk.sv
module pls_status_chk (
    input wire logic clk, rst_n, master_declare, slave_declare,
    input wire logic channel_select_bit, port_multi_assigned,
    input wire logic network_enable, volume_read_instruction,
    input wire logic volume_scale_instruction, variant_high_end,
    input wire logic variant_new, run_mode, power_on_pulse,
    input wire logic comm_error, rx_busy,
    input wire logic [1:0] error_kind,
    input wire logic receive_activity_indicator, link_active_flag,
    input wire logic station_setting_error_flag, channel_enable_first,
    input wire logic channel_enable_second,
    input wire logic serial_error_flag_first_channel,
    input wire logic serial_error_flag_second_channel,
    input wire logic [15:0] error_code_word_first_channel,
    input wire logic [15:0] error_code_word_second_channel
);
    timeunit 1ns;
    timeprecision 1ps;
    logic run_q;
    wire f1 = serial_error_flag_first_channel;
    wire f2 = serial_error_flag_second_channel;
    wire [15:0] c1 = error_code_word_first_channel;
    wire [15:0] c2 = error_code_word_second_channel;
    wire sel = channel_select_bit;
    wire vol = volume_read_instruction | volume_scale_instruction;
    wire blk = network_enable | port_multi_assigned
             | vol & (variant_high_end ^ sel);
    wire hit = comm_error & !blk;
    wire same = master_declare == slave_declare;
    wire [15:0] want = error_kind == 2'h0 ? 16'h0000
                     : (sel ? 16'h3811 : 16'h6311) + {14'h0000, error_kind};
    // Older parts clear on the stop-to-run edge, also seen just after reset since run_q is held low
    always @(posedge clk) run_q <= rst_n & run_mode;
    wire clr = variant_new ? power_on_pulse : run_mode & !run_q;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_err1; hit && !sel; endsequence
    sequence s_err2; hit && sel; endsequence
    sequence s_quiet; clr && !comm_error; endsequence
    chk_flag_first: assert property (
        s_err1 |=> f1 && c1 == $past(want))
        else $error("first channel error not recorded");
    chk_flag_second: assert property (
        s_err2 |=> f2 && c2 == $past(want))
        else $error("second channel error not recorded");
    chk_link_drop: assert property (hit |=> !link_active_flag)
        else $error("link flag kept after error");
    chk_setting_error: assert property ($past(rst_n) |->
        station_setting_error_flag == $past(same)) else $error("setting flag");
    chk_flags_sticky: assert property (!clr |=>
        f1 >= $past(f1) && f2 >= $past(f2)) else $error("flag dropped");
    chk_code_hold: assert property (!hit && !clr |=>
        $stable(c1) && $stable(c2)) else $error("code changed");
    chk_clear_all: assert property (s_quiet |=>
        !f1 && !f2 && c1 == 16'h0000 && c2 == 16'h0000) else $error("no clear");
    chk_idle_dark: assert property (
        !rx_busy |=> !receive_activity_indicator)
        else $error("receive indicator lit while idle");
    chk_port_block: assert property (port_multi_assigned |=>
        !channel_enable_first && !channel_enable_second) else $error("port on");
endmodule
bind pls_status pls_status_chk chk_u (.*);

// File: testbench/pls_peer.sv
module pls_peer (
    input  wire logic       clk, rst_n, rx_req, tx_req, fault,
    input  wire logic [1:0] fault_kind,
    output wire logic       link_ok, rx_busy, tx_busy, comm_error,
    output wire logic [1:0] error_kind
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] junk = 2'h0;
    // Kind lines mean nothing outside a fault, so they keep moving
    always @(negedge clk) junk <= junk + 2'h1;
    assign link_ok = rst_n;
    assign rx_busy = rx_req;
    assign tx_busy = tx_req;
    assign comm_error = fault;
    assign error_kind = fault ? fault_kind : junk;
endmodule

// File: testbench/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_n = 0, mst = 1, slv = 0, sel = 0, multi = 0, ok;
    logic vr = 0, vs = 0, vnew = 0, hi = 0, run = 1, pwr = 0, ly, rxb, txb;
    logic rxr = 0, txr = 0, flt = 0, ce;
    logic [1:0] fk = 2'h0, ek;
    wire rxi, txi, lnk, se, f1, f2, en1, en2;
    wire [15:0] c1, c2;
    logic [15:0] x1, x2;
    logic [1:0] xf;
    logic [31:0] seed = 32'h2f35;
    int fails = 0, checks = 0, on0, on1;
    pls_status dut_u (.clk(clk), .rst_n(rst_n), .master_declare(mst),
        .slave_declare(slv), .channel_select_bit(sel), .network_enable(1'b0),
        .port_multi_assigned(multi), .volume_read_instruction(vr),
        .volume_scale_instruction(vs), .variant_new(vnew),
        .variant_high_end(hi), .run_mode(run), .power_on_pulse(pwr),
        .link_ok(ly), .rx_busy(rxb), .tx_busy(txb), .comm_error(ce),
        .error_kind(ek), .receive_activity_indicator(rxi),
        .transmit_activity_indicator(txi), .link_active_flag(lnk),
        .station_setting_error_flag(se),
        .serial_error_flag_first_channel(f1),
        .serial_error_flag_second_channel(f2),
        .error_code_word_first_channel(c1),
        .error_code_word_second_channel(c2),
        .channel_enable_first(en1), .channel_enable_second(en2));
    pls_peer peer_u (.clk(clk), .rst_n(rst_n), .rx_req(rxr), .tx_req(txr),
        .fault(flt), .fault_kind(fk), .link_ok(ly), .rx_busy(rxb),
        .tx_busy(txb), .comm_error(ce), .error_kind(ek));
    always #4 clk = ~clk;
    function automatic logic [31:0] rnd(logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    function automatic logic [15:0] code(logic ch, logic [1:0] k);
        if (k == 2'h0)
            return 16'h0000;
        return (ch ? 16'h3811 : 16'h6311) + {14'h0000, k};
    endfunction
    task chk(string s, logic [33:0] seen, logic [33:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s exp %h seen %h", s, exp, seen);
        end
    endtask
    task complete_run();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        #20000;
        fails++;
        complete_run();
    end
    initial begin
        repeat (2) @(negedge clk);
        rst_n = 1;
        for (int d = 0; d < 2; d++) begin
            rxr = d == 0;
            txr = d == 1;
            on0 = 0;
            on1 = 0;
            repeat (12) begin
                @(negedge clk);
                on0 += rxi;
                on1 += txi;
            end
            chk("flash", {on0 != 0, on1 != 0}, {rxr, txr});
        end
        rxr = 0;
        txr = 0;
        repeat (2) @(negedge clk);
        chk("dark", {rxi, txi}, 0);
        for (int n = 0; n < 24; n++) begin
            seed = rnd(seed);
            {vnew, hi, mst, slv} = seed[3:0];
            {vr, vs, multi} = {&seed[5:4], &seed[7:6], &seed[10:8]};
            sel = n[2];
            fk = n[1:0];
            // power pulse clears the records on new parts; the settings act at once
            pwr = 1;
            @(negedge clk);
            pwr = 0;
            flt = 1;
            ok = !multi && !((vr || vs) && (hi ^ sel));
            xf = {ok && !sel, ok && sel};
            x1 = ok && !sel ? code(1'b0, fk) : 16'h0000;
            x2 = ok && sel ? code(1'b1, fk) : 16'h0000;
            @(negedge clk);
            flt = 0;
            chk("setting", se, mst == slv);
            chk("flags", {f1, f2}, xf);
            chk("code1", c1, x1);
            chk("code2", c2, x2);
            if (ok)
                chk("link", lnk, 0);
            repeat (3) @(negedge clk);
            chk("sticky", {f1, f2, c1, c2}, {xf, x1, x2});
            pwr = vnew;
            run = vnew;
            @(negedge clk);
            pwr = 0;
            run = 1;
            @(negedge clk);
            chk("clear", {f1, f2, c1, c2}, 0);
            @(negedge clk);
            chk("link_up", lnk, ok && mst != slv);
            chk("enable", {en1, en2}, xf);
        end
        complete_run();
    end
endmodule
